// File: logic/cht_timing_core.sv
`timescale 1ns/1ps
`default_nettype none
module cht_timing_core
  import cht_pkg::*;
#(
  parameter int DATA_W = 10
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ref_clock_in,
  output logic inverted_clock_out,
  input wire logic serial_load_in,
  input wire logic serial_data_in,
  input wire logic serial_clock_in,
  output logic reset_gate_pulse_out,
  output logic horiz_clock_one_out,
  output logic horiz_clock_two_out,
  output logic horiz_clock_three_out,
  output logic horiz_clock_four_out,
  output logic [NUM_DRV*DRV_W-1:0] driver_current_ctrl_out,
  output logic [NUM_DRV-1:0] driver_oe_n_out,
  output logic precharge_sample_strobe_out,
  output logic data_sample_strobe_out,
  input wire logic ext_sync_in,
  input wire logic line_sync_in,
  output logic line_sync_out,
  output logic line_sync_oe_n_out,
  input wire logic field_sync_in,
  output logic field_sync_out,
  output logic field_sync_oe_n_out,
  input wire logic [DATA_W-1:0] pixel_data_in,
  input wire logic pixel_data_valid_in,
  output logic pixel_data_ready_out,
  output logic [DATA_W-1:0] data_out,
  output logic data_valid_out,
  input wire logic data_ready_in,
  output logic pixel_data_clock_out,
  output logic [CNT_W-1:0] pixel_count_out,
  output logic [CNT_W-1:0] line_count_out
);
  // pin synchronisers: ref, load, data, sck, ext sync, line, field
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_meta;
  logic [NSYNC-1:0] pin_stab;
  logic [NSYNC-1:0] pin_prev;
  logic ref_s, sl_s, sdi_s, sck_s, sync_s, line_s, field_s;
  logic ref_rise, sl_rise, sl_fall, sck_rise;
  logic sync_fall, line_fall, field_fall;

  // registers
  logic ref_clock_halve_sel;
  logic [12:0] prog_edges [NUM_PROG];
  logic [5:0] sample_loc;
  logic [14:0] driver_current_ctrl;
  logic [8:0] output_phase_ctrl;
  logic slave_mode;
  logic [CNT_W-1:0] line_len;
  logic [CNT_W-1:0] field_len;

  // serial receiver
  logic [SER_BITS-1:0] ser_shift;
  logic [5:0] ser_cnt;
  logic ser_commit;
  logic [SER_ADDR_W-1:0] ser_addr;
  logic [SER_DATA_W-1:0] ser_data;

  // timing core
  logic half_tog;
  logic pixel_start;
  logic [5:0] phase;
  logic [NUM_PROG-1:0] wave_lvl;
  logic [NUM_PROG-1:0] next_wave_lvl;
  logic [6:0] samp_dec;
  logic [5:0] shd_pos;
  logic [6:0] out_dec;
  logic [5:0] out_dist;
  logic [MAX_DELAY_CYC:0] launch_pipe;
  logic launch_tap;
  logic [CNT_W-1:0] hcount;
  logic [CNT_W-1:0] vcount;

  cht_buf_if #(.W(DATA_W)) dbuf ();

  // valid codes give {1, position}; reserved low nibbles 12..15 give no edge
  function automatic logic [6:0] decode_edge(input logic [5:0] code);
    logic [5:0] base;
    base = 6'(code[5:4] * 6'd12);
    if (code[3:0] < 4'(QUAD_SPAN))
      decode_edge = {1'b1, 6'(base + {2'b00, code[3:0]})};
    else
      decode_edge = 7'h00;
  endfunction

  // two flip-flops before anything reads a pin
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      pin_meta <= '0;
      pin_stab <= '0;
      pin_prev <= '0;
    end
    else
    begin
      pin_meta <= {field_sync_in, line_sync_in, ext_sync_in, serial_clock_in,
                   serial_data_in, serial_load_in, ref_clock_in};
      pin_stab <= pin_meta;
      pin_prev <= pin_stab;
    end
  end
  assign {field_s, line_s, sync_s, sck_s, sdi_s, sl_s, ref_s} = pin_stab;
  assign ref_rise = ref_s && !pin_prev[0];
  assign sl_fall = !sl_s && pin_prev[1];
  assign sl_rise = sl_s && !pin_prev[1];
  assign sck_rise = sck_s && !pin_prev[3];
  assign sync_fall = !sync_s && pin_prev[4];
  assign line_fall = !line_s && pin_prev[5];
  assign field_fall = !field_s && pin_prev[6];

  // serial shift: load low frames a word, bits enter lsb first on sck rise
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || sl_fall)
    begin
      ser_shift <= '0;
      ser_cnt <= '0;
    end
    else if (!sl_s && sck_rise)
    begin
      ser_shift <= {sdi_s, ser_shift[SER_BITS-1:1]};
      if (ser_cnt != 6'(SER_BITS))
        ser_cnt <= 6'(ser_cnt + 1'b1);
    end
  end
  // a short word is dropped rather than written half-formed
  assign ser_commit = sl_rise && (ser_cnt == 6'(SER_BITS));
  assign ser_addr = ser_shift[SER_ADDR_W-1:0];
  assign ser_data = ser_shift[SER_BITS-1:SER_ADDR_W];

  // register writes
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ref_clock_halve_sel <= 1'b0;
      prog_edges[0] <= RST_RG_EDGES;
      prog_edges[1] <= RST_H1_EDGES;
      prog_edges[2] <= RST_H3_EDGES;
      sample_loc <= RST_SAMPLE_LOC;
      driver_current_ctrl <= RST_DRV_CTRL;
      output_phase_ctrl <= RST_OUT_PHASE;
      slave_mode <= 1'b0;
      line_len <= RST_LINE_LEN;
      field_len <= RST_FIELD_LEN;
    end
    else if (ser_commit)
    begin
      case (ser_addr)
        REG_CLK_HALVE: ref_clock_halve_sel <= ser_data[0];
        REG_RG_EDGES: prog_edges[0] <= ser_data[12:0];
        REG_H1_EDGES: prog_edges[1] <= ser_data[12:0];
        REG_H3_EDGES: prog_edges[2] <= ser_data[12:0];
        REG_SAMPLE_LOC: sample_loc <= ser_data[5:0];
        REG_DRV_CTRL: driver_current_ctrl <= ser_data[14:0];
        REG_SYNC_CFG: slave_mode <= ser_data[0];
        REG_OUT_PHASE: output_phase_ctrl <= ser_data[8:0];
        REG_FRAME_LEN:
        begin
          line_len <= ser_data[F_LINE_LSB +: CNT_W];
          field_len <= ser_data[F_FIELD_LSB +: CNT_W];
        end
        default: ;
      endcase
    end
  end

  // pixel start: every ref rise, or every other one when halving
  assign pixel_start = ref_rise && (!ref_clock_halve_sel || !half_tog);
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      half_tog <= 1'b0;
    else if (ref_rise)
      half_tog <= ref_clock_halve_sel ? !half_tog : 1'b0;
  end

  // edge position counter, realigned at each pixel start
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pixel_start)
      phase <= '0;
    else if (phase == 6'(EDGE_POS - 1))
      phase <= '0;
    else
      phase <= 6'(phase + 1'b1);
  end

  // rg, h1, h3: set at rise position, clear at fall; same in both modes
  for (genvar g = 0; g < NUM_PROG; g++)
  begin : g_wave
    logic [6:0] rise_dec;
    logic [6:0] fall_dec;
    assign rise_dec = decode_edge(prog_edges[g][F_RISE_LSB +: CODE_W]);
    assign fall_dec = decode_edge(prog_edges[g][F_FALL_LSB +: CODE_W]);
    always_comb
    begin
      next_wave_lvl[g] = wave_lvl[g];
      if (rise_dec[6] && rise_dec[5:0] == phase)
        next_wave_lvl[g] = 1'b1;
      else if (fall_dec[6] && fall_dec[5:0] == phase)
        next_wave_lvl[g] = 1'b0;
    end
    always_ff @(posedge clk_in)
    begin
      if (sys_rst_in)
        wave_lvl[g] <= 1'b0;
      else
        wave_lvl[g] <= next_wave_lvl[g];
    end
  end

  // polarity applied last; two and four are inverses of one and three
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      reset_gate_pulse_out <= 1'b0;
      horiz_clock_one_out <= 1'b0;
      horiz_clock_two_out <= 1'b1;
      horiz_clock_three_out <= 1'b0;
      horiz_clock_four_out <= 1'b1;
    end
    else
    begin
      reset_gate_pulse_out <= next_wave_lvl[0] ^ prog_edges[0][F_POL_BIT];
      horiz_clock_one_out <= next_wave_lvl[1] ^ prog_edges[1][F_POL_BIT];
      horiz_clock_two_out <= !(next_wave_lvl[1] ^ prog_edges[1][F_POL_BIT]);
      horiz_clock_three_out <= next_wave_lvl[2] ^ prog_edges[2][F_POL_BIT];
      horiz_clock_four_out <= !(next_wave_lvl[2] ^ prog_edges[2][F_POL_BIT]);
    end
  end

  // sample strobes: precharge at the setting, data half a pixel later
  assign samp_dec = decode_edge(sample_loc);
  assign shd_pos = (samp_dec[5:0] >= 6'(EDGE_POS / 2)) ?
                   6'(samp_dec[5:0] - 6'(EDGE_POS / 2)) :
                   6'(samp_dec[5:0] + 6'(EDGE_POS / 2));
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      precharge_sample_strobe_out <= 1'b0;
      data_sample_strobe_out <= 1'b0;
    end
    else
    begin
      precharge_sample_strobe_out <= samp_dec[6] && samp_dec[5:0] == phase;
      data_sample_strobe_out <= samp_dec[6] && shd_pos == phase;
    end
  end

  // driver strength codes go to the pads; code 0 floats the driver
  for (genvar d = 0; d < NUM_DRV; d++)
  begin : g_drv
    always_ff @(posedge clk_in)
    begin
      if (sys_rst_in)
        driver_oe_n_out[d] <= 1'b0;
      else
        driver_oe_n_out[d] <= (driver_current_ctrl[d*DRV_W +: DRV_W] == '0);
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      driver_current_ctrl_out <= RST_DRV_CTRL;
    else
      driver_current_ctrl_out <= driver_current_ctrl;
  end

  // crystal driver output
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      inverted_clock_out <= 1'b1;
    else
      inverted_clock_out <= !ref_s;
  end

  // pixel and line counters; sync inputs override the free-running wrap
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      hcount <= '0;
      vcount <= '0;
    end
    else if (!slave_mode && sync_fall)
    begin
      hcount <= '0;
      vcount <= '0;
    end
    else if (slave_mode && (line_fall || field_fall))
    begin
      hcount <= '0;
      if (field_fall)
        vcount <= '0;
      else if (vcount != CNT_W'(4095))
        vcount <= CNT_W'(vcount + 1'b1);
    end
    else if (pixel_start)
    begin
      if (hcount >= CNT_W'(line_len - 1'b1) && !slave_mode)
      begin
        hcount <= '0;
        vcount <= (vcount >= CNT_W'(field_len - 1'b1)) ? '0 : CNT_W'(vcount + 1'b1);
      end
      else if (hcount != CNT_W'(4095))
        hcount <= CNT_W'(hcount + 1'b1);
    end
  end

  // sync pins: driven low at count zero in master, released in slave
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      line_sync_out <= 1'b1;
      field_sync_out <= 1'b1;
      line_sync_oe_n_out <= 1'b0;
      field_sync_oe_n_out <= 1'b0;
      pixel_count_out <= '0;
      line_count_out <= '0;
    end
    else
    begin
      line_sync_out <= !(hcount == '0);
      field_sync_out <= !(vcount == '0);
      line_sync_oe_n_out <= slave_mode;
      field_sync_oe_n_out <= slave_mode;
      pixel_count_out <= hcount;
      line_count_out <= vcount;
    end
  end

  // data path: two-entry buffer absorbs a receiver stall
  assign dbuf.in_valid = pixel_data_valid_in;
  assign dbuf.in_data = pixel_data_in;
  assign pixel_data_ready_out = dbuf.in_ready;

  cht_data_buf #(.W(DATA_W), .DEPTH(2)) u_buf (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .bus(dbuf)
  );

  // launch position, then 0 to 2 cycles of added output delay
  assign out_dec = decode_edge(output_phase_ctrl[F_PHASE_LSB +: CODE_W]);
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      launch_pipe <= '0;
    else
      launch_pipe <= {launch_pipe[MAX_DELAY_CYC-1:0],
                      out_dec[6] && out_dec[5:0] == phase};
  end
  always_comb
  begin
    case (output_phase_ctrl[F_DELAY_LSB +: 2])
      2'd0: launch_tap = launch_pipe[0];
      2'd1: launch_tap = launch_pipe[(DELAY_STEP_NS*1000 + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS];
      2'd2: launch_tap = launch_pipe[(2*DELAY_STEP_NS*1000 + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS];
      default: launch_tap = launch_pipe[MAX_DELAY_CYC];
    endcase
  end
  assign dbuf.out_ready = launch_tap && data_ready_in;

  // output word register; a stalled receiver leaves the word in the buffer
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      data_out <= '0;
      data_valid_out <= 1'b0;
    end
    else
    begin
      data_valid_out <= dbuf.out_valid && dbuf.out_ready;
      if (dbuf.out_valid && dbuf.out_ready)
        data_out <= dbuf.out_data;
    end
  end

  // data clock: high for half a pixel from launch, or fixed to the crystal phase
  assign out_dist = (phase >= out_dec[5:0]) ? 6'(phase - out_dec[5:0]) :
                    6'(phase + 6'(EDGE_POS) - out_dec[5:0]);
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      pixel_data_clock_out <= 1'b0;
    else if (output_phase_ctrl[F_PIXEL_DATA_CLOCK_OUT_FIXED_BIT])
      pixel_data_clock_out <= !ref_s;
    else if (out_dec[6])
      pixel_data_clock_out <= (out_dist < 6'(EDGE_POS / 2));
  end
endmodule
`default_nettype wire

// File: shared/cht_pkg.sv
// Summary of operation
// - each pixel period (one reference period, two when halving) splits into 48 edge positions; edges sit on them
// - clock-halving register at 0x30 divides the reference clock by two
// - clock output pin is the inverse of the reference clock input
// - reset-gate pulse has programmable rise, fall and whole-pulse polarity
// - horizontal clocks one/three programmable; two/four always their inverses
// - edge settings are 6-bit codes; 48 valid codes in four quadrants
// - upper two bits pick the quadrant, lower four bits hold 0 to 11
// - polarity bit zero leaves a clock uninverted, one inverts it
// - one 6-bit setting places the precharge and data sample strobes
// - 3-bit strength per driver in 0x35; code 0 turns the driver off
// - bits 5:0 of 0x37 pick the data launch position; data clock follows
// - bit 6 of 0x37 fixes the data clock to the inverted reference clock
// - bits 8:7 of 0x37 add 0, 4, 8 or 12 ns of output delay; default 8; code rounds up to 0, 1, 1 or 2 cycles (0, 8, 8, 16 ns)
// - 12-bit pixel and line counters; at most 4095 pixels and 4095 lines
// - master mode drives line/field sync; external sync resets counters
// - slave mode takes line/field sync as inputs and follows them
// - edge and strobe generation is the same in master and slave mode
package cht_pkg;
  localparam int EDGE_POS = 48;
  localparam int QUAD_SPAN = 12;
  localparam int CODE_W = 6;
  localparam int CNT_W = 12;
  localparam int DRV_W = 3;
  localparam int NUM_DRV = 5;
  localparam int NUM_PROG = 3;
  // serial word: 12 address bits then 24 data bits, lsb first
  localparam int SER_ADDR_W = 12;
  localparam int SER_DATA_W = 24;
  localparam int SER_BITS = SER_ADDR_W + SER_DATA_W;
  // register offsets
  localparam logic [11:0] REG_CLK_HALVE = 12'h030;
  localparam logic [11:0] REG_RG_EDGES = 12'h031;
  localparam logic [11:0] REG_H1_EDGES = 12'h032;
  localparam logic [11:0] REG_H3_EDGES = 12'h033;
  localparam logic [11:0] REG_SAMPLE_LOC = 12'h034;
  localparam logic [11:0] REG_DRV_CTRL = 12'h035;
  localparam logic [11:0] REG_SYNC_CFG = 12'h036;
  localparam logic [11:0] REG_OUT_PHASE = 12'h037;
  localparam logic [11:0] REG_FRAME_LEN = 12'h038;
  // edge register fields: rise [5:0], fall [11:6], polarity [12]
  localparam int F_RISE_LSB = 0;
  localparam int F_FALL_LSB = 6;
  localparam int F_POL_BIT = 12;
  // output phase fields
  localparam int F_PHASE_LSB = 0;
  localparam int F_PIXEL_DATA_CLOCK_OUT_FIXED_BIT = 6;
  localparam int F_DELAY_LSB = 7;
  // frame length fields: line length [11:0], field length [23:12]
  localparam int F_LINE_LSB = 0;
  localparam int F_FIELD_LSB = 12;
  // reset values
  localparam logic [12:0] RST_RG_EDGES = 13'h0200;
  localparam logic [12:0] RST_H1_EDGES = 13'h0800;
  localparam logic [12:0] RST_H3_EDGES = 13'h0800;
  localparam logic [5:0] RST_SAMPLE_LOC = 6'h10;
  localparam logic [14:0] RST_DRV_CTRL = 15'h7fff;
  localparam logic [8:0] RST_OUT_PHASE = 9'h100;
  localparam logic [11:0] RST_LINE_LEN = 12'hfff;
  localparam logic [11:0] RST_FIELD_LEN = 12'hfff;
  // output delay steps and their cycle counts at 125 MHz
  localparam int CLK_PERIOD_PS = 8000;
  localparam int DELAY_STEP_NS = 4;
  localparam int MAX_DELAY_NS = 12;
  localparam int MAX_DELAY_CYC =
    (MAX_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// File: shared/cht_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries words into and out of the two-entry data buffer
interface cht_buf_if #(parameter int W = 10);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport core (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
  modport buffer (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// File: logic/cht_data_buf.sv
`timescale 1ns/1ps
`default_nettype none
module cht_data_buf #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  cht_buf_if.buffer bus
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [W-1:0] rd_data;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign bus.in_ready = (count != DEPTH[PW:0]);
  assign bus.out_valid = (count != '0);
  assign bus.out_data = rd_data;
  assign push = bus.in_valid && bus.in_ready;
  assign pop = bus.out_valid && bus.out_ready;

  // storage, no reset needed on data
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr] <= bus.in_data;
  end

  // read data kept in a register, shows the word at the head
  always_ff @(posedge clk_in)
  begin
    if (push && (count == '0 || (pop && count == 1)))
      rd_data <= bus.in_data;
    else if (pop)
      rd_data <= mem[PW'(rd_ptr + 1'b1)];
  end

  // pointers and count
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= PW'(wr_ptr + 1'b1);
      if (pop)
        rd_ptr <= PW'(rd_ptr + 1'b1);
      if (push && !pop)
        count <= (PW+1)'(count + 1'b1);
      else if (pop && !push)
        count <= (PW+1)'(count - 1'b1);
    end
  end
endmodule
`default_nettype wire

// File: bench/cht_timing_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cht_timing_core_sva
  import cht_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ref_clock_in,
  input wire logic inverted_clock_out,
  input wire logic horiz_clock_one_out,
  input wire logic horiz_clock_two_out,
  input wire logic horiz_clock_three_out,
  input wire logic horiz_clock_four_out,
  input wire logic [NUM_DRV*DRV_W-1:0] driver_current_ctrl_out,
  input wire logic [NUM_DRV-1:0] driver_oe_n_out,
  input wire logic precharge_sample_strobe_out,
  input wire logic data_sample_strobe_out,
  input wire logic ext_sync_in,
  input wire logic line_sync_in,
  input wire logic line_sync_oe_n_out,
  input wire logic data_valid_out,
  input wire logic data_ready_in,
  input wire logic [CNT_W-1:0] pixel_count_out
);
  logic [2:0] age;
  // cycles since reset, so the input synchroniser is full before judging
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      age <= 3'h0;
    else if (age != 3'h7)
      age <= age + 3'h1;
  end
  function automatic logic [NUM_DRV-1:0] off_mask(logic [NUM_DRV*DRV_W-1:0] c);
    for (int i = 0; i < NUM_DRV; i++)
      off_mask[i] = (c[i*DRV_W +: DRV_W] == 3'h0);
  endfunction
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_ext_fall;
    $fell(ext_sync_in) && !line_sync_oe_n_out;
  endsequence
  sequence s_slave_fall;
    $fell(line_sync_in) && line_sync_oe_n_out;
  endsequence
  sequence s_pix_zero;
    ##[2:6] pixel_count_out == 12'h000;
  endsequence
  a_h2_inverse: assert property (horiz_clock_two_out == !horiz_clock_one_out)
    else $error("clock two not inverse of one");
  a_h4_inverse: assert property (horiz_clock_four_out == !horiz_clock_three_out)
    else $error("clock four not inverse of three");
  a_clk_inverse: assert property (age > 3'h3 |-> inverted_clock_out == !$past(ref_clock_in, 3))
    else $error("clock output not inverse of reference");
  a_strobe_pair: assert property (precharge_sample_strobe_out |-> ##24 data_sample_strobe_out)
    else $error("data strobe not 24 positions after precharge");
  a_drv_off: assert property (driver_oe_n_out == off_mask(driver_current_ctrl_out))
    else $error("driver enable does not match code");
  a_pix_step: assert property ($changed(pixel_count_out) |->
    pixel_count_out == $past(pixel_count_out) + 12'h001 || pixel_count_out == 12'h000)
    else $error("pixel count jumped");
  a_ext_sync: assert property (s_ext_fall |-> s_pix_zero)
    else $error("external sync did not clear counters");
  a_slave_line: assert property (s_slave_fall |-> s_pix_zero)
    else $error("slave line sync did not clear pixel count");
  a_launch_ready: assert property (data_valid_out |-> $past(data_ready_in))
    else $error("word launched while receiver stalled");
endmodule
bind cht_timing_core cht_timing_core_sva i_cht_timing_core_sva (.*);
`default_nettype wire

// File: bench/cht_proc_model.sv
`timescale 1ns/1ps
`default_nettype none
// processor side: free-running reference clock and a receiver that may stall
module cht_proc_model (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic fast_in,
  input wire logic stall_in,
  output logic ref_clock_out,
  output logic data_ready_out
);
  int ph = 0;
  // one pixel is 48 system cycles; a doubled reference halves that
  always @(posedge clk_in)
    ph <= (ph >= (fast_in ? 23 : 47)) ? 0 : ph + 1;
  assign ref_clock_out = ph < (fast_in ? 12 : 24);
  // a receiver in reset takes nothing
  assign data_ready_out = !stall_in && !sys_rst_in;
endmodule
`default_nettype wire

// File: bench/cht_timing_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cht_timing_core_tb;
  import cht_pkg::*;
  localparam int DLY = 1;
  logic clk_in;
  logic sys_rst_in = 1'b1;
  logic serial_load_in = 1'b1;
  logic serial_data_in = 1'b0;
  logic serial_clock_in = 1'b0;
  logic ext_sync_in = 1'b1;
  logic line_sync_in = 1'b1;
  logic field_sync_in = 1'b1;
  logic [9:0] pixel_data_in = 10'h000;
  logic pixel_data_valid_in = 1'b0;
  logic fast = 1'b0;
  logic stall = 1'b0;
  wire logic ref_clock_in, inverted_clock_out, reset_gate_pulse_out, data_ready_in;
  wire logic horiz_clock_one_out, horiz_clock_two_out, horiz_clock_three_out;
  wire logic horiz_clock_four_out, precharge_sample_strobe_out, data_sample_strobe_out;
  wire logic line_sync_out, line_sync_oe_n_out, field_sync_out, field_sync_oe_n_out;
  wire logic pixel_data_ready_out, data_valid_out, pixel_data_clock_out;
  wire logic [14:0] driver_current_ctrl_out;
  wire logic [4:0] driver_oe_n_out;
  wire logic [9:0] data_out;
  wire logic [11:0] pixel_count_out, line_count_out;
  wire logic [3:0] mon = {precharge_sample_strobe_out, horiz_clock_three_out,
    horiz_clock_one_out, reset_gate_pulse_out};
  int n_errors = 0;
  int n_tests = 0;
  int n, cyc_n = 0, t_str = 0, exp_dist = 0;
  bit chk_ph = 1'b0;
  logic [9:0] exp_q[$];
  logic [5:0] r, f;
  logic p;
  logic [14:0] d;
  logic [11:0] v;
  cht_timing_core i_cht_timing_core (.*);
  cht_proc_model i_cht_proc_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .fast_in(fast), .stall_in(stall), .ref_clock_out(ref_clock_in),
    .data_ready_out(data_ready_in));
  // free-running system clock
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic end_sim();
    $display("Checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk_in);
    #DLY;
  endtask
  // serial word, lsb first; every level held 4 cycles for the synchroniser
  task automatic wr(logic [11:0] a, logic [23:0] w);
    logic [35:0] s;
    s = {w, a};
    serial_load_in = 1'b0;
    cyc(4);
    for (int i = 0; i < 36; i++)
    begin
      serial_data_in = s[i];
      cyc(4);
      serial_clock_in = 1'b1;
      cyc(4);
      serial_clock_in = 1'b0;
    end
    cyc(4);
    serial_load_in = 1'b1;
    cyc(8);
  endtask
  task automatic meas(int k, output int cnt);
    cnt = 0;
    repeat (48)
    begin
      cyc(1);
      cnt += int'(mon[k]);
    end
  endtask
  // holds each word until the buffer takes it
  task automatic push(int k);
    repeat (k)
    begin
      pixel_data_in = 10'($urandom);
      pixel_data_valid_in = 1'b1;
      @(posedge clk_in);
      while (pixel_data_ready_out !== 1'b1)
        @(posedge clk_in);
      exp_q.push_back(pixel_data_in);
      #DLY;
    end
    pixel_data_valid_in = 1'b0;
  endtask
  task automatic at_strobe();
    @(posedge precharge_sample_strobe_out);
    #DLY;
  endtask
  function automatic int pos(logic [5:0] c);
    return int'(c[5:4]) * 12 + int'(c[3:0]);
  endfunction
  // high cycles per pixel; a reserved fall code or a tie leaves the level high
  function automatic int hi_exp(logic [5:0] ri, logic [5:0] fa, logic po);
    int h;
    h = (pos(fa) - pos(ri) + 48) % 48;
    if (fa[3:2] == 2'b11 || h == 0)
      h = 48;
    return po ? 48 - h : h;
  endfunction
  function automatic logic [4:0] off(logic [14:0] c);
    for (int i = 0; i < 5; i++)
      off[i] = c[3*i +: 3] == 3'h0;
  endfunction
  function automatic logic [5:0] rcode();
    return {2'($urandom), 4'($urandom % 12)};
  endfunction
  // output words in order, and their distance from the precharge strobe
  always @(negedge clk_in)
  begin
    if (precharge_sample_strobe_out === 1'b1)
      t_str = cyc_n;
    if (data_valid_out === 1'b1)
    begin
      chk("data word", exp_q.pop_front(), data_out);
      if (chk_ph)
        chk("launch distance", exp_dist, cyc_n - t_str);
    end
    cyc_n++;
  end
  // cuts a hang short
  initial
  begin
    #480000;
    n_errors++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'hf767));
    repeat (4) @(posedge clk_in);
    #DLY;
    sys_rst_in = 1'b0;
    chk("drive codes", RST_DRV_CTRL, driver_current_ctrl_out);
    chk("clocks two four", 2'b11, {horiz_clock_two_out, horiz_clock_four_out});
    d = 15'($urandom) & 15'h7ff8;
    wr(REG_DRV_CTRL, {9'h000, d});
    chk("drive codes", d, driver_current_ctrl_out);
    chk("driver enables", off(d), driver_oe_n_out);
    for (int k = 0; k < 3; k++)
      for (int t = 0; t < 2; t++)
      begin
        r = rcode();
        f = t ? {2'($urandom), 2'b11, 2'($urandom)} : rcode();
        p = 1'($urandom);
        wr(REG_RG_EDGES + 12'(k), {11'h000, p, f, r});
        cyc(96);
        meas(k, n);
        chk("high count", hi_exp(r, f, p), n);
      end
    wr(REG_H3_EDGES, {11'h000, p, f, r});
    meas(3, n);
    chk("strobes per pixel", 1, n);
    // strobes parked on a reserved code while the reference is swapped: realigning splits pairs
    at_strobe();
    cyc(24);
    wr(REG_SAMPLE_LOC, 24'h00000c);
    meas(3, n);
    chk("reserved strobes", 0, n);
    wr(REG_CLK_HALVE, 24'h000001);
    fast = 1'b1;
    wr(REG_SAMPLE_LOC, {18'h00000, RST_SAMPLE_LOC});
    meas(3, n);
    chk("halved strobes", 1, n);
    at_strobe();
    cyc(24);
    wr(REG_SAMPLE_LOC, 24'h00000c);
    fast = 1'b0;
    wr(REG_CLK_HALVE, 24'h000000);
    wr(REG_SAMPLE_LOC, {18'h00000, RST_SAMPLE_LOC});
    stall = 1'b1;
    fork
      push(3);
    join_none
    cyc(150);
    chk("words held", 2, exp_q.size());
    stall = 1'b0;
    cyc(300);
    chk("words left", 0, exp_q.size());
    for (int i = 0; i < 4; i++)
    begin
      n = $urandom % 48;
      wr(REG_OUT_PHASE, {15'h0000, 2'(i), 1'b0, 2'(n / 12), 4'(n % 12)});
      exp_dist = (n - pos(RST_SAMPLE_LOC) + 1 + (i == 0 ? 0 : i == 3 ? 2 : 1) + 48) % 48;
      chk_ph = 1'b1;
      push(3);
      cyc(200);
      chk_ph = 1'b0;
    end
    // fixed data clock follows the inverted reference, three cycles behind the pin
    wr(REG_OUT_PHASE, 24'h000140);
    @(posedge ref_clock_in);
    cyc(4);
    v[0] = pixel_data_clock_out;
    cyc(24);
    chk("fixed data clock", 2'b10, {pixel_data_clock_out, v[0]});
    wr(REG_SYNC_CFG, 24'h000001);
    chk("sync drive", 2'b11, {line_sync_oe_n_out, field_sync_oe_n_out});
    at_strobe();
    v = line_count_out;
    line_sync_in = 1'b0;
    cyc(8);
    chk("pixel count", 12'h000, pixel_count_out);
    chk("line count", v + 12'h001, line_count_out);
    line_sync_in = 1'b1;
    at_strobe();
    field_sync_in = 1'b0;
    cyc(8);
    chk("line count", 12'h000, line_count_out);
    field_sync_in = 1'b1;
    meas(3, n);
    chk("slave strobes", 1, n);
    wr(REG_SYNC_CFG, 24'h000000);
    chk("sync drive", 2'b00, {line_sync_oe_n_out, field_sync_oe_n_out});
    cyc(100);
    at_strobe();
    ext_sync_in = 1'b0;
    cyc(8);
    chk("counts", 26'h0000000, {pixel_count_out, line_count_out,
      line_sync_out, field_sync_out});
    ext_sync_in = 1'b1;
    cyc(8);
    end_sim();
  end
endmodule
`default_nettype wire
